/* File: verilog/tcc_defines.vh */
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------
`define TCC_OFS_STATUS_CONTROL 4'h0
`define TCC_OFS_COUNT_HIGH     4'h4
`define TCC_OFS_COUNT_LOW      4'h8
`define TCC_OFS_MODULO         4'hC
`define TCC_OFS_PIN_CONTROL    5'h10

// ----------------------------------------
// Status/control field positions
// ----------------------------------------
`define TCC_BIT_OVF            7
`define TCC_BIT_OVF_IE         6
`define TCC_BIT_CENTER         5
`define TCC_CLKS_HI            4
`define TCC_CLKS_LO            3
`define TCC_PS_HI              2
`define TCC_PS_LO              0

// ----------------------------------------
// Clock source codes
// ----------------------------------------
`define TCC_CLK_NONE           2'h0
`define TCC_CLK_BUS            2'h1
`define TCC_CLK_FIXED          2'h2
`define TCC_CLK_EXT            2'h3

// ----------------------------------------
// Reset values and full-range modulo
// ----------------------------------------
`define TCC_RST_SC             8'h00
`define TCC_RST_COUNT          16'h0000
`define TCC_RST_MODULO         16'h0000
`define TCC_RST_PIN_CONTROL    8'h00
`define TCC_MOD_FULL           16'hFFFF

`endif

/* File: verilog/tcc_prescaler.v */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Prescaler: one tick every 2^ps source events
// ----------------------------------------
module tcc_prescaler (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Control
	input  wire       src_evt_i,
	input  wire [2:0] ps_i,
	input  wire       hold_i,
	// Result
	output reg        tick_o
);

	reg  [6:0] div_cnt;
	wire [6:0] div_mask;

	assign div_mask = (7'h01 << ps_i) - 7'h01;

	always @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt <= 7'h00;
			tick_o  <= 1'b0;
		end else if (hold_i) begin
			tick_o  <= 1'b0;
		end else if (src_evt_i) begin
			if ((div_cnt & div_mask) == div_mask) begin
				div_cnt <= 7'h00;
				tick_o  <= 1'b1;
			end else begin
				div_cnt <= div_cnt + 7'h01;
				tick_o  <= 1'b0;
			end
		end else begin
			tick_o  <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* File: verilog/tcc_core.v */
// Functional notes
// (R01) After reset the timer is off and pins are inputs, pullups off.
// (R02) External clock must run below half bus rate, quarter rate recommended.
// (R03) External and fixed clocks pass a two-flop bus-clock synchroniser.
// (R04) Software sets channel edge select to 0:0 when its pin clocks timer.
// (R05) While timer owns a pin, port data and direction are ignored.
// (R06) A channel needing no pin returns it to general-purpose I/O.
// (R07) Up mode: overflow flag sets when counter rolls to zero past modulo.
// (R08) Center mode: overflow flag sets on step down after reaching modulo.
// (R09) Flag clears only by read-while-set then write 0; writing 1 does nothing.
// (R10) Overflow during clear sequence restarts it so the flag stays set.
// (R11) Overflow request is high whenever flag and enable bit 6 are both set.
// (R12) Bit 5 set gives up/down center-aligned counting, clear gives up counting.
// (R13) Clock field 4:3: none, bus clock, fixed clock, external pin.
// (R14) Prescale field 2:0 divides the synchronised clock by 2^field.
// (R15) Counter bytes read-only; reading one latches both until other is read.
// (R16) Latch rearmed by reset, any counter write, or status/control write.
// (R17) Reset clears the counter.
// (R18) Reset clears flag, enable and center select: up-counting start.
// (R19) Any write to a counter byte resets the counter.
// (R20) Modulo 0x0000 or 0xFFFF lets the counter run full range.
// (R21) At modulo: up mode restarts at zero, center mode counts down.
// (R22) Debug freeze halts counter and latch; reads leave latch unchanged.
// (R23) Counter steps once per prescaler tick and holds when no clock.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defines.vh"

module tcc_core (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [4:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Clock sources and debug
	input  wire        fixed_system_clock_i,
	input  wire        external_timer_clock_pin_i,
	input  wire        debug_freeze_i,
	// Channel pin ownership requests
	input  wire [7:0]  chan_pin_need_i,
	input  wire [7:0]  chan_pin_drive_i,
	input  wire [7:0]  chan_pin_value_i,
	input  wire [7:0]  port_data_i,
	input  wire [7:0]  port_dir_i,
	// Pins
	output reg  [7:0]  pin_out_o,
	output reg  [7:0]  pin_oe_o,
	output reg  [7:0]  pin_pullup_o,
	// Channel side
	output reg  [15:0] count_o,
	output reg         overflow_evt_o,
	output reg         center_aligned_select_o,
	output reg         overflow_irq_o
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg        overflow_flag;
	reg        overflow_irq_enable;
	reg        center_aligned_select;
	reg [1:0]  clock_source_field;
	reg [2:0]  prescale_field;
	reg [15:0] counter_modulo_value;
	reg [7:0]  pullup_enable;
	reg [15:0] count;
	reg        count_down;
	reg        clr_armed;
	reg        latch_valid;
	reg        latch_first_high;
	reg [15:0] count_latch;
	reg        fix_s1, fix_s2, fix_s3;
	reg        ext_s1, ext_s2, ext_s3;

	wire       wb_req;
	wire       wr;
	wire       rd;
	wire       sel_sc;
	wire       sel_hi;
	wire       sel_lo;
	wire       sel_mod;
	wire       sel_pin;
	wire       tick;
	reg        src_evt;
	reg        next_ovf_evt;
	reg [15:0] next_count;
	reg        next_down;
	wire [7:0] sc_val;
	wire       full_range;

	function is_rise;
		input prev;
		input cur;
		begin
			is_rise = cur & ~prev;
		end
	endfunction

	assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr      = wb_req & wb_we_i & wb_sel_i[0];
	assign rd      = wb_req & ~wb_we_i;
	assign sel_sc  = (wb_adr_i == {1'b0, `TCC_OFS_STATUS_CONTROL});
	assign sel_hi  = (wb_adr_i == {1'b0, `TCC_OFS_COUNT_HIGH});
	assign sel_lo  = (wb_adr_i == {1'b0, `TCC_OFS_COUNT_LOW});
	assign sel_mod = (wb_adr_i == {1'b0, `TCC_OFS_MODULO});
	assign sel_pin = (wb_adr_i == `TCC_OFS_PIN_CONTROL);
	assign sc_val  = {overflow_flag, overflow_irq_enable, center_aligned_select,
	                  clock_source_field, prescale_field};
	// (R20) full-range
	assign full_range = (counter_modulo_value == `TCC_RST_MODULO) ||
	                    (counter_modulo_value == `TCC_MOD_FULL);

	// ----------------------------------------
	// Clock source synchronisers
	// ----------------------------------------
	// (R03) two-flop sync
	always @(posedge clk_i) begin
		if (rst_i) begin
			fix_s1 <= 1'b0;
			fix_s2 <= 1'b0;
			fix_s3 <= 1'b0;
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			fix_s1 <= fixed_system_clock_i;
			fix_s2 <= fix_s1;
			fix_s3 <= fix_s2;
			ext_s1 <= external_timer_clock_pin_i;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	// (R13) source select
	always @* begin
		case (clock_source_field)
			`TCC_CLK_BUS:   src_evt = 1'b1;
			`TCC_CLK_FIXED: src_evt = is_rise(fix_s3, fix_s2);
			// (R02) slow ext clock
			`TCC_CLK_EXT:   src_evt = is_rise(ext_s3, ext_s2);
			default:        src_evt = 1'b0;
		endcase
	end

	// (R14) prescale divide
	tcc_prescaler u_prescaler (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.src_evt_i (src_evt),
		.ps_i      (prescale_field),
		.hold_i    (debug_freeze_i | (clock_source_field == `TCC_CLK_NONE)),
		.tick_o    (tick)
	);

	// ----------------------------------------
	// Counter next state
	// ----------------------------------------
	always @* begin
		next_count   = count;
		next_down    = count_down;
		next_ovf_evt = 1'b0;
		if (!center_aligned_select) begin
			next_down = 1'b0;
			// (R07) (R21) up roll
			if (!full_range && count == counter_modulo_value) begin
				next_count   = 16'h0000;
				next_ovf_evt = 1'b1;
			end else begin
				next_count   = count + 16'h0001;
				next_ovf_evt = (count == `TCC_MOD_FULL);
			end
		end else begin
			// (R12) up/down mode
			if (!count_down) begin
				if ((!full_range && count == counter_modulo_value) ||
				    count == `TCC_MOD_FULL) begin
					// (R08) step down
					next_count   = count - 16'h0001;
					next_down    = 1'b1;
					next_ovf_evt = 1'b1;
				end else begin
					next_count = count + 16'h0001;
				end
			end else if (count == 16'h0000) begin
				next_count = 16'h0001;
				next_down  = 1'b0;
			end else begin
				next_count = count - 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Register file and counter
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			// (R17) (R18) reset state
			overflow_flag           <= 1'b0;
			overflow_irq_enable     <= 1'b0;
			center_aligned_select   <= 1'b0;
			clock_source_field      <= `TCC_CLK_NONE;
			prescale_field          <= 3'h0;
			counter_modulo_value    <= `TCC_RST_MODULO;
			pullup_enable           <= `TCC_RST_PIN_CONTROL;
			count                   <= `TCC_RST_COUNT;
			count_down              <= 1'b0;
			clr_armed               <= 1'b0;
			latch_valid             <= 1'b0;
			latch_first_high        <= 1'b0;
			count_latch             <= 16'h0000;
			overflow_evt_o          <= 1'b0;
			wb_ack_o                <= 1'b0;
			wb_dat_o                <= 32'h00000000;
		end else begin
			wb_ack_o       <= wb_req;
			overflow_evt_o <= 1'b0;
			// (R23) step per tick
			if (tick && !debug_freeze_i) begin
				count          <= next_count;
				count_down     <= next_down;
				overflow_evt_o <= next_ovf_evt;
			end
			// (R09) arm on read
			if (rd && sel_sc && overflow_flag)
				clr_armed <= 1'b1;
			if (wr && sel_sc) begin
				overflow_irq_enable   <= wb_dat_i[`TCC_BIT_OVF_IE];
				center_aligned_select <= wb_dat_i[`TCC_BIT_CENTER];
				clock_source_field    <= wb_dat_i[`TCC_CLKS_HI:`TCC_CLKS_LO];
				prescale_field        <= wb_dat_i[`TCC_PS_HI:`TCC_PS_LO];
				clr_armed             <= 1'b0;
				// (R09) write-0 clear
				if (clr_armed && !wb_dat_i[`TCC_BIT_OVF])
					overflow_flag <= 1'b0;
			end
			// (R10) set wins, rearm
			if (tick && !debug_freeze_i && next_ovf_evt) begin
				overflow_flag <= 1'b1;
				clr_armed     <= 1'b0;
			end
			if (wr && sel_mod && wb_sel_i[1])
				counter_modulo_value <= wb_dat_i[15:0];
			if (wr && sel_pin)
				pullup_enable <= wb_dat_i[7:0];
			// (R19) write resets
			if (wr && (sel_hi || sel_lo)) begin
				count      <= `TCC_RST_COUNT;
				count_down <= 1'b0;
			end
			// (R15) (R22) coherent latch, frozen in debug
			if (rd && (sel_hi || sel_lo) && !debug_freeze_i) begin
				if (!latch_valid) begin
					latch_valid      <= 1'b1;
					latch_first_high <= sel_hi;
					count_latch      <= count;
				end else if (latch_first_high != sel_hi) begin
					latch_valid <= 1'b0;
				end
			end
			// (R16) rearm latch
			if (wr && (sel_hi || sel_lo || sel_sc))
				latch_valid <= 1'b0;
			wb_dat_o <= 32'h00000000;
			if (rd) begin
				if (sel_sc)
					wb_dat_o <= {24'h000000, sc_val};
				else if (sel_hi)
					wb_dat_o <= {24'h000000, latch_valid ? count_latch[15:8] : count[15:8]};
				else if (sel_lo)
					wb_dat_o <= {24'h000000, latch_valid ? count_latch[7:0] : count[7:0]};
				else if (sel_mod)
					wb_dat_o <= {16'h0000, counter_modulo_value};
				else if (sel_pin)
					wb_dat_o <= {24'h000000, pullup_enable};
			end
		end
	end

	// ----------------------------------------
	// Pins and outputs
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			// (R01) inputs, no pullup
			pin_out_o               <= 8'h00;
			pin_oe_o                <= 8'h00;
			pin_pullup_o            <= 8'h00;
			count_o                 <= 16'h0000;
			center_aligned_select_o <= 1'b0;
			overflow_irq_o          <= 1'b0;
		end else begin
			// (R05) (R06) pin ownership
			pin_out_o    <= (chan_pin_need_i & chan_pin_value_i) |
			                (~chan_pin_need_i & port_data_i);
			pin_oe_o     <= (chan_pin_need_i & chan_pin_drive_i) |
			                (~chan_pin_need_i & port_dir_i);
			// Pullup only on pins the timer holds as inputs
			pin_pullup_o <= pullup_enable & chan_pin_need_i & ~chan_pin_drive_i;
			count_o      <= count;
			center_aligned_select_o <= center_aligned_select;
			// (R11) irq request
			overflow_irq_o <= overflow_flag & overflow_irq_enable;
		end
	end

endmodule

`default_nettype wire

/* File: test/tcc_core_props.sv */
`timescale 1ns/100ps
`default_nettype none

module tcc_core_props (
	// Clock, reset, bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [4:0]  wb_adr_i,
	input wire logic        wb_ack_o,
	// Pins and counter
	input wire logic        debug_freeze_i,
	input wire logic [7:0]  chan_pin_need_i,
	input wire logic [7:0]  chan_pin_drive_i,
	input wire logic [7:0]  port_dir_i,
	input wire logic [7:0]  pin_oe_o,
	input wire logic [7:0]  pin_pullup_o,
	input wire logic [15:0] count_o,
	input wire logic        overflow_evt_o,
	input wire logic        center_aligned_select_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	wire       req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [7:0] oe_exp = (chan_pin_need_i & chan_pin_drive_i) | (~chan_pin_need_i & port_dir_i);
	wire [7:0] no_pu  = ~chan_pin_need_i | chan_pin_drive_i;

	property p_ack; req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bus request not answered");
	property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
	property p_rst; $fell(rst_i) |-> count_o == 16'h0000 && !center_aligned_select_o; endproperty
	a_rst: assert property (p_rst) else $error("state not cleared by reset");
	property p_oe; !$past(rst_i) |-> pin_oe_o == $past(oe_exp); endproperty
	a_oe: assert property (p_oe) else $error("pin enable owner wrong");
	property p_pu; !$past(rst_i) |-> (pin_pullup_o & $past(no_pu)) == 8'h00; endproperty
	a_pu: assert property (p_pu) else $error("pullup on a pin not used as input");
	property p_ovf; overflow_evt_o && !center_aligned_select_o |-> ##[0:1] count_o == 16'h0000;
	endproperty
	a_ovf: assert property (p_ovf) else $error("up overflow not at zero");
	property p_frz; debug_freeze_i [*3] |-> $stable(count_o); endproperty
	a_frz: assert property (p_frz) else $error("counter moved while frozen");
	property p_cwr; req && wb_we_i && (wb_adr_i == 5'h04 || wb_adr_i == 5'h08)
		|=> ##1 count_o == 16'h0000; endproperty
	a_cwr: assert property (p_cwr) else $error("counter write did not zero it");
endmodule

bind tcc_core tcc_core_props u_tcc_core_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_ack_o(wb_ack_o), .debug_freeze_i(debug_freeze_i), .chan_pin_need_i(chan_pin_need_i),
	.chan_pin_drive_i(chan_pin_drive_i), .port_dir_i(port_dir_i), .pin_oe_o(pin_oe_o),
	.pin_pullup_o(pin_pullup_o), .count_o(count_o), .overflow_evt_o(overflow_evt_o),
	.center_aligned_select_o(center_aligned_select_o));

`default_nettype wire

/* File: test/test_tcc_core.sv */
`timescale 1ns/100ps
`default_nettype none

module test_tcc_core;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic        ack;
	logic        frz = 1'b0;
	logic [2:0]  ph = 3'h0;
	logic [7:0]  need = 8'h00;
	logic [7:0]  drv = 8'h00;
	logic [7:0]  val = 8'h00;
	logic [7:0]  pdat = 8'h00;
	logic [7:0]  pdir = 8'h00;
	logic [7:0]  p_out, p_oe, p_pu;
	logic [15:0] cnt;
	logic        evt, cas, irq;
	integer      fails = 0;
	integer      n_tests = 0;

	always #12.5 clk_i = ~clk_i;
	// Fixed clock at 1/8 and external at 1/4 of the bus rate
	always @(posedge clk_i) ph <= ph + 3'h1;

	tcc_core u_tcc_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .fixed_system_clock_i(ph[2]), .external_timer_clock_pin_i(ph[1]),
		.debug_freeze_i(frz), .chan_pin_need_i(need), .chan_pin_drive_i(drv),
		.chan_pin_value_i(val), .port_data_i(pdat), .port_dir_i(pdir), .pin_out_o(p_out),
		.pin_oe_o(p_oe), .pin_pullup_o(p_pu), .count_o(cnt), .overflow_evt_o(evt),
		.center_aligned_select_o(cas), .overflow_irq_o(irq));

	task chk(input [15:0] g, input [15:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task wb(input [4:0] a, input w, input [31:0] d, output [31:0] q);
		integer k;
		@(posedge clk_i);
		adr <= a;
		we <= w;
		wdat <= d;
		cyc <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = rdat;
		cyc <= 1'b0;
		if (k == 50) begin
			fails++;
			$display("Error t=%0t no ack adr=%h got=%h exp=%h", $time, a, ack, 1'b1);
		end
	endtask

	task wait_evt;
		integer k;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (evt !== 1'b1 && k < 1000);
		if (k == 1000) begin
			fails++;
			$display("Error t=%0t no overflow got=%h exp=%h", $time, evt, 1'b1);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		logic [31:0] q;
		chk(cnt, 16'h0000);
		chk({p_oe, p_pu}, 16'h0000);
		wb(5'h00, 1'b0, 0, q);
		chk(q[7:0], 8'h00);
		$display("test reset done");
	endtask

	task t_rate(input [7:0] sc, input integer n, input [15:0] e);
		logic [31:0] q;
		logic [15:0] c;
		wb(5'h00, 1'b1, {24'h0, sc}, q);
		repeat (40) @(posedge clk_i);
		c = cnt;
		repeat (n) @(posedge clk_i);
		chk(cnt - c, e);
		$display("test rate %h done", sc);
	endtask

	task t_ovf;
		logic [31:0] q;
		wb(5'h0C, 1'b1, 3, q);
		wb(5'h00, 1'b1, 8'h4F, q);
		// Count is far above the modulo here; restart it or the wrap takes millions of cycles
		wb(5'h04, 1'b1, 0, q);
		wait_evt;
		repeat (3) @(posedge clk_i);
		chk(irq, 1'b1);
		wb(5'h00, 1'b0, 0, q);
		chk(q[7:0], 8'hCF);
		wait_evt;
		wb(5'h00, 1'b1, 8'h4F, q);
		wb(5'h00, 1'b0, 0, q);
		chk(q[7], 1'b1);
		wb(5'h00, 1'b1, 8'h40, q);
		wb(5'h00, 1'b1, 8'hC0, q);
		wb(5'h00, 1'b0, 0, q);
		chk(q[7:0], 8'h40);
		chk(irq, 1'b0);
		$display("test overflow done");
	endtask

	task t_mode(input [7:0] sc, input [15:0] e);
		logic [31:0] q;
		logic [15:0] p;
		integer k;
		integer m;
		wb(5'h00, 1'b1, {24'h0, sc}, q);
		wb(5'h08, 1'b1, 0, q);
		p = cnt;
		m = n_tests;
		for (k = 0; k < 24; k++) begin
			@(posedge clk_i);
			if (p == 16'h0003 && cnt !== 16'h0003) chk(cnt, e);
			p = cnt;
		end
		// The turn at the modulo value must have been seen at least once
		chk(n_tests > m, 1'b1);
		chk(cas, sc[5]);
		$display("test mode %h done", sc);
	endtask

	task t_coh;
		logic [31:0] a;
		logic [15:0] c;
		logic [7:0]  h;
		wb(5'h0C, 1'b1, 0, a);
		wb(5'h00, 1'b1, 8'h08, a);
		wb(5'h04, 1'b1, 8'hFF, a);
		repeat (20) @(posedge clk_i);
		wb(5'h08, 1'b0, 0, a);
		repeat (600) @(posedge clk_i);
		wb(5'h04, 1'b0, 0, a);
		chk(a[7:0], 8'h00);
		wb(5'h04, 1'b0, 0, a);
		chk(a[7:0] > 8'h01, 1'b1);
		// Latch is held here; the status write must release it
		wb(5'h00, 1'b1, 8'h08, a);
		repeat (600) @(posedge clk_i);
		wb(5'h04, 1'b0, 0, a);
		chk(a[7:0] > 8'h03, 1'b1);
		h = a[7:0];
		frz <= 1'b1;
		repeat (4) @(posedge clk_i);
		c = cnt;
		// Low byte read while frozen must not release the high-first latch
		wb(5'h08, 1'b0, 0, a);
		repeat (50) @(posedge clk_i);
		chk(cnt, c);
		frz <= 1'b0;
		repeat (600) @(posedge clk_i);
		wb(5'h04, 1'b0, 0, a);
		chk(a[7:0], h);
		$display("test coherent read done");
	endtask

	task t_pins;
		logic [31:0] q;
		need <= 8'h0F;
		drv <= 8'h05;
		val <= 8'h05;
		pdat <= 8'hA0;
		pdir <= 8'hF0;
		wb(5'h10, 1'b1, 8'hFF, q);
		repeat (3) @(posedge clk_i);
		chk({p_oe, p_out}, 16'hF5A5);
		chk(p_pu, 8'h0A);
		need <= 8'h00;
		wb(5'h14, 1'b0, 0, q);
		chk(q[15:0], 16'h0000);
		chk(p_oe, 8'hF0);
		$display("test pins done");
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		for (int i = 0; i < 8; i++) t_rate(8'h08 | i[7:0], 8 << i, 16'h0008);
		t_rate(8'h00, 64, 16'h0000);
		t_rate(8'h10, 64, 16'h0008);
		// External clock pin is left unclaimed by every channel
		t_rate(8'h18, 64, 16'h0010);
		t_ovf;
		t_mode(8'h08, 16'h0000);
		t_mode(8'h28, 16'h0002);
		t_coh;
		t_pins;
		finish_test;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		$display("Error t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
		finish_test;
	end
endmodule

`default_nettype wire
